// File: src/asc_top.sv
// Purpose: sample sequencer, channel scanner, timers and interrupter
// Assumes: all inputs synchronous to core_clk_in
// Notes:   results pass a FIFO before landing in the per-channel array
`timescale 1ns/1ps

// ********************************************************************
// result FIFO
// ********************************************************************
module asc_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 32
) (
   // clock
   input  wire logic             core_clk_in,
   input  wire logic             rst_in,
   input  wire logic             ce_in,
   // fill side
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   // drain side
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("fifo depth must be a power of two");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0]      wp_q;
   logic [AW:0]      rp_q;
   logic             push;
   logic             pop;

   assign in_ready_out  = (wp_q - rp_q) != (AW+1)'(DEPTH);
   assign out_valid_out = wp_q != rp_q;
   assign out_data_out  = mem_q[rp_q[AW-1:0]];
   assign push = in_valid_in & in_ready_out;
   assign pop  = out_valid_out & out_ready_in;

   always_ff @(posedge core_clk_in) begin
      if (ce_in && push) begin
         mem_q[wp_q[AW-1:0]] <= in_data_in;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         wp_q <= '0;
         rp_q <= '0;
      end else if (ce_in) begin
         if (push) wp_q <= wp_q + 1'b1;
         if (pop) rp_q <= rp_q + 1'b1;
      end
   end
endmodule : asc_fifo

module asc_top
   import asc_pkg::*;
#(
   parameter logic [7:0] BOARD_CODE     = 8'h5a, // arbitrary value
   parameter int         TRACK_LONG_CNT = asc_pkg::TRACK_LONG_CYC
) (
   // clock and reset
   input  wire logic                        core_clk_in,
   input  wire logic                        rst_in,
   input  wire logic                        ce_in,
   // backplane register port
   input  wire logic                        bus_sel_in,
   input  wire logic [6:0]                  bus_addr_in,
   input  wire logic                        bus_write_n_in,
   input  wire logic                        bus_ds0_n_in,
   input  wire logic                        bus_ds1_n_in,
   input  wire logic                        bus_iack_in,
   input  wire logic [2:0]                  bus_iack_lvl_in,
   input  wire logic [15:0]                 bus_data_in,
   output logic      [15:0]                 bus_data_out,
   output logic                             bus_data_oe_out,
   output logic                             bus_ack_out,
   output logic      [7:1]                  bus_irq_n_out,
   // converter and selectors
   output logic      [asc_pkg::CHAN_W-1:0]  channel_select_lines_out,
   output logic      [1:0]                  bit_ref_sel_out,
   output logic                             hold_out,
   output logic                             convert_strobe_out,
   input  wire logic                        conversion_in_progress_in,
   input  wire logic [asc_pkg::DATA_W-1:0]  adc_data_in,
   // straps
   input  wire logic [6:0]                  scan_length_straps_in
);
   import asc_pkg::*;

   if (TRACK_LONG_CNT < 1 || TRACK_LONG_CNT > 65535) begin : g_chk
      $error("TRACK_LONG_CNT out of range");
   end

   // ****************************************************************
   // register port
   // ****************************************************************
   logic        acc;
   logic        acc_q;
   logic        start_acc;
   logic        wr_go;
   logic        rd_go;
   logic        iak_go;
   logic        mine_q;
   logic        iack_q;
   logic [15:0] bmask;
   logic [15:0] rd_mux;
   logic [15:0] csr_rd;

   logic [15:0] csr_q;
   logic [15:0] tctl_q;
   logic [15:0] ictl_q;
   logic [15:0] tld_q [NTMR];
   logic [15:0] tcnt_q [NTMR];
   logic        fresh_q;
   logic        sweep_q;
   logic        irq_pend_q;
   logic [DATA_W-1:0] single_q;
   logic [DATA_W-1:0] dp_mem_q [NCHAN];

   assign acc       = bus_sel_in & ~(bus_ds0_n_in & bus_ds1_n_in);
   assign start_acc = acc & ~acc_q;
   assign wr_go     = start_acc & ~bus_iack_in & ~bus_write_n_in;
   assign rd_go     = start_acc & ~bus_iack_in & bus_write_n_in;
   assign iak_go    = start_acc & bus_iack_in & irq_pend_q
                      & (bus_iack_lvl_in == ictl_q[ICTL_LVL_LO +: 3]);
   assign bmask     = {{8{~bus_ds1_n_in}}, {8{~bus_ds0_n_in}}};
   assign bus_ack_out     = acc & acc_q & (~iack_q | mine_q);
   assign bus_data_oe_out = bus_ack_out & (bus_write_n_in | mine_q);

   always_comb begin
      rd_mux = 16'h0000;
      if (bus_addr_in[DP_BIT]) begin
         rd_mux[DATA_W-1:0] = dp_mem_q[bus_addr_in[CHAN_W-1:0]];
      end else begin
         unique case (bus_addr_in)
            REG_ID:   rd_mux = {BOARD_CODE, 8'h00};
            REG_CSR:  rd_mux = csr_rd;
            REG_RES:  rd_mux[DATA_W-1:0] = single_q;
            REG_TCTL: rd_mux = tctl_q;
            7'h04:    rd_mux = tcnt_q[0];
            7'h05:    rd_mux = tcnt_q[1];
            7'h06:    rd_mux = tcnt_q[2];
            REG_ICTL: rd_mux = ictl_q;
            default:  rd_mux = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         acc_q  <= 1'b0;
         iack_q <= 1'b0;
         mine_q <= 1'b0;
         bus_data_out <= 16'h0000;
      end else if (ce_in) begin
         acc_q <= acc;
         if (start_acc) begin
            iack_q <= bus_iack_in;
            mine_q <= iak_go;
         end
         if (iak_go) begin
            bus_data_out <= {8'h00, ictl_q[ICTL_VEC_LO +: 8]};
         end else if (rd_go) begin
            bus_data_out <= rd_mux;
         end
      end
   end

   // ****************************************************************
   // control registers
   // ****************************************************************
   logic start_wr;
   assign start_wr = wr_go & (bus_addr_in == REG_CSR) & ~bus_ds0_n_in
                     & bus_data_in[CSR_START];

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         csr_q  <= CSR_RST;
         tctl_q <= TCTL_RST;
         ictl_q <= ICTL_RST;
         for (int i = 0; i < NTMR; i++) tld_q[i] <= TLD_RST;
      end else if (ce_in && wr_go) begin
         if (bus_addr_in == REG_CSR) begin
            csr_q <= (csr_q & ~bmask) | (bus_data_in & bmask);
         end
         if (bus_addr_in == REG_TCTL) begin
            tctl_q <= (tctl_q & ~bmask) | (bus_data_in & bmask);
         end
         if (bus_addr_in == REG_ICTL) begin
            ictl_q <= (ictl_q & ~bmask) | (bus_data_in & bmask);
         end
         for (int i = 0; i < NTMR; i++) begin
            if (bus_addr_in == REG_TLD0 + 7'(i)) begin
               tld_q[i] <= (tld_q[i] & ~bmask) | (bus_data_in & bmask);
            end
         end
      end
   end

   // ****************************************************************
   // interval timers
   // ****************************************************************
   logic [NTMR-1:0] tick;
   logic [NTMR-1:0] uf;
   logic            tmr_trig;

   for (genvar g = 0; g < NTMR; g++) begin : g_tmr
      if (g == 0) begin : g_first
         assign tick[g] = tctl_q[TCTL_RUN];
      end else begin : g_next
         assign tick[g] = tctl_q[TCTL_C01 + g - 1] ? uf[g-1]
                          : tctl_q[TCTL_RUN];
      end
      assign uf[g] = tick[g] & (tcnt_q[g] == 16'h0000);
      always_ff @(posedge core_clk_in) begin
         if (rst_in) begin
            tcnt_q[g] <= TLD_RST;
         end else if (ce_in && tick[g]) begin
            tcnt_q[g] <= uf[g] ? tld_q[g] : tcnt_q[g] - 16'h0001;
         end
      end
   end
   assign tmr_trig = uf[NTMR-1] & tctl_q[TCTL_TRIG];

   // ****************************************************************
   // sample sequencer
   // ****************************************************************
   typedef enum logic [2:0] {
      S_IDLE, S_SETTLE, S_TRACK, S_CONV, S_BUSY, S_STORE
   } asc_state_t;

   asc_state_t        st_q;
   asc_mode_t         mode;
   logic [15:0]       cnt_q;
   logic [CHAN_W-1:0] chan_q;
   logic [CHAN_W-1:0] last_ch;
   logic [DATA_W-1:0] smp_q;
   logic              busy_q;
   logic              scan_mode;
   logic              auto_mode;
   logic              scan_go;
   logic              push_ok;
   logic              fifo_rdy;
   logic              last_done;
   logic              conv_done;
   logic              ev_single;
   logic [15:0]       track_len;

   assign mode      = asc_mode_t'(csr_q[CSR_MODE_LO +: 3]);
   assign auto_mode = (mode == MODE_AUTO) || (mode == MODE_AUTO_BIT);
   assign scan_mode = auto_mode || (mode == MODE_SCAN_POLL)
                      || (mode == MODE_SCAN_INT);
   assign last_ch   = (scan_length_straps_in == 7'h00
                       || scan_length_straps_in > 7'h40) ? 6'h3f
                      : 6'(scan_length_straps_in - 7'h01);
   assign track_len = csr_q[CSR_LONG] ? 16'(TRACK_LONG_CNT)
                      : 16'(TRACK_CYC);
   assign scan_go   = start_wr | tmr_trig;
   assign push_ok   = (st_q == S_STORE) & scan_mode & fifo_rdy;
   assign last_done = push_ok & (chan_q == last_ch);
   assign ev_single = (st_q == S_STORE) & ~scan_mode;
   assign conv_done = busy_q & ~conversion_in_progress_in;

   assign channel_select_lines_out = chan_q;
   assign bit_ref_sel_out = (mode == MODE_AUTO_BIT && chan_q == 6'h00)
                            ? csr_q[CSR_REF_LO +: 2] : 2'b00;
   assign hold_out = (st_q == S_CONV) || (st_q == S_BUSY);
   assign convert_strobe_out = (st_q == S_CONV);

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         busy_q <= 1'b0;
      end else if (ce_in) begin
         busy_q <= conversion_in_progress_in;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         st_q   <= S_IDLE;
         cnt_q  <= 16'h0000;
         chan_q <= '0;
         smp_q  <= '0;
      end else if (ce_in) begin
         cnt_q <= cnt_q + 16'h0001;
         unique case (st_q)
            S_IDLE: begin
               cnt_q <= 16'h0000;
               if (auto_mode || (scan_mode && scan_go)) begin
                  chan_q <= '0;
                  st_q   <= S_SETTLE;
               end else if (!scan_mode && start_wr) begin
                  chan_q <= bus_data_in[CSR_MUX_LO +: CHAN_W];
                  st_q   <= S_SETTLE;
               end
            end
            S_SETTLE: if (cnt_q == 16'(SETTLE_CYC - 1)) begin
               cnt_q <= 16'h0000;
               st_q  <= S_TRACK;
            end
            S_TRACK: if (cnt_q == track_len - 16'h0001) begin
               st_q <= S_CONV;
            end
            S_CONV: if (conversion_in_progress_in) begin
               st_q <= S_BUSY;
            end
            S_BUSY: if (conv_done) begin
               smp_q <= adc_data_in;
               st_q  <= S_STORE;
            end
            S_STORE: begin
               cnt_q <= 16'h0000;
               if (!scan_mode) begin
                  st_q <= S_IDLE;
               end else if (fifo_rdy) begin
                  chan_q <= chan_q + 6'h01;
                  st_q   <= S_SETTLE;
                  if (chan_q == last_ch) begin
                     chan_q <= '0;
                     st_q <= auto_mode ? S_SETTLE : S_IDLE;
                  end
               end
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // result path: FIFO into per-channel array
   // ****************************************************************
   asc_res_t fifo_out;
   logic     drain_valid;
   logic     drain_ready;

   assign drain_ready = ~(rd_go & bus_addr_in[DP_BIT]);

   asc_fifo #(
      .WIDTH ($bits(asc_res_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .core_clk_in   (core_clk_in),
      .rst_in        (rst_in),
      .ce_in         (ce_in),
      .in_valid_in   (push_ok),
      .in_ready_out  (fifo_rdy),
      .in_data_in    ({chan_q, smp_q}),
      .out_valid_out (drain_valid),
      .out_ready_in  (drain_ready),
      .out_data_out  (fifo_out)
   );

   always_ff @(posedge core_clk_in) begin
      if (ce_in && drain_valid && drain_ready) begin
         dp_mem_q[fifo_out.chan] <= fifo_out.data;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         single_q <= '0;
      end else if (ce_in && ev_single) begin
         single_q <= smp_q;
      end
   end

   // ****************************************************************
   // status flags and interrupter
   // ****************************************************************
   logic rd_single;
   logic irq_ev;
   assign rd_single = rd_go & (bus_addr_in == REG_RES);
   assign irq_ev = (ev_single && mode == MODE_RAND_INT)
                   || (last_done && mode == MODE_SCAN_INT);

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         fresh_q <= 1'b0;
         sweep_q <= 1'b0;
      end else if (ce_in) begin
         if (ev_single) fresh_q <= 1'b1;
         else if (rd_single) fresh_q <= 1'b0;
         if (st_q == S_IDLE && scan_mode && !auto_mode && scan_go) begin
            sweep_q <= 1'b0;
         end
         if (last_done && (mode == MODE_SCAN_POLL
                           || mode == MODE_SCAN_INT)) begin
            sweep_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         irq_pend_q <= 1'b0;
      end else if (ce_in) begin
         if (irq_ev) irq_pend_q <= 1'b1;
         else if (iak_go) irq_pend_q <= 1'b0;
      end
   end

   for (genvar l = 1; l <= 7; l++) begin : g_irq
      assign bus_irq_n_out[l] =
         ~(irq_pend_q && ictl_q[ICTL_LVL_LO +: 3] == 3'(l));
   end

   // status view merged into control/status reads
   always_comb begin
      csr_rd = csr_q;
      csr_rd[CSR_BUSY]  = (st_q != S_IDLE);
      csr_rd[CSR_SWEEP] = sweep_q;
      csr_rd[CSR_FRESH] = fresh_q;
      csr_rd[CSR_START] = 1'b0;
   end
endmodule : asc_top

// File: src/asc_pkg.sv
// Purpose: shared constants and types for the scan converter control
// Assumes: 250 MHz core clock, 16-bit register port, word indices
// Notes:   times are kept in ns, cycle counts derived from them
package asc_pkg;

   // ****************************************************************
   // clock and timing
   // ****************************************************************
   localparam int CLK_MHZ        = 250;
   localparam int SETTLE_NS      = 5000;
   localparam int TRACK_NS       = 10000;
   localparam int TRACK_LONG_NS  = 23000;
   localparam int SETTLE_CYC     = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int TRACK_CYC      = (TRACK_NS * CLK_MHZ + 999) / 1000;
   localparam int TRACK_LONG_CYC = (TRACK_LONG_NS * CLK_MHZ + 999) / 1000;

   // ****************************************************************
   // sizes
   // ****************************************************************
   localparam int DATA_W     = 12;
   localparam int CHAN_W     = 6;
   localparam int NCHAN      = 64;
   localparam int FIFO_DEPTH = 32;
   localparam int NTMR       = 3;

   // ****************************************************************
   // register word indices (bus address lines 7:1)
   // ****************************************************************
   localparam logic [6:0] REG_ID   = 7'h00;
   localparam logic [6:0] REG_CSR  = 7'h01;
   localparam logic [6:0] REG_RES  = 7'h02;
   localparam logic [6:0] REG_TCTL = 7'h03;
   localparam logic [6:0] REG_TLD0 = 7'h04;
   localparam logic [6:0] REG_ICTL = 7'h07;
   localparam int         DP_BIT   = 6;

   // ****************************************************************
   // control/status word fields
   // ****************************************************************
   localparam int CSR_LONG   = 15;
   localparam int CSR_MUX_LO = 9;
   localparam int CSR_MODE_LO = 6;
   localparam int CSR_BUSY   = 5;
   localparam int CSR_SWEEP  = 4;
   localparam int CSR_FRESH  = 3;
   localparam int CSR_START  = 2;
   localparam int CSR_REF_LO = 0;

   // timer control: bit0 run, bit1 cascade 0->1, bit2 cascade 1->2,
   // bit3 timer 2 output starts a scan
   localparam int TCTL_RUN  = 0;
   localparam int TCTL_C01  = 1;
   localparam int TCTL_C12  = 2;
   localparam int TCTL_TRIG = 3;

   // interrupt control: bits 2:0 level, bits 15:8 vector
   localparam int ICTL_LVL_LO = 0;
   localparam int ICTL_VEC_LO = 8;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [15:0] CSR_RST  = 16'h0000;
   localparam logic [15:0] TCTL_RST = 16'h0000;
   localparam logic [15:0] ICTL_RST = 16'h0000;
   localparam logic [15:0] TLD_RST  = 16'hffff;

   typedef enum logic [2:0] {
      MODE_AUTO     = 3'b000,
      MODE_RAND_POLL = 3'b001,
      MODE_RAND_INT = 3'b010,
      MODE_SCAN_POLL = 3'b011,
      MODE_SCAN_INT = 3'b100,
      MODE_AUTO_BIT = 3'b111
   } asc_mode_t;

   typedef struct packed {
      logic [CHAN_W-1:0] chan;
      logic [DATA_W-1:0] data;
   } asc_res_t;

endpackage : asc_pkg

// File: verification/asc_top_asserts.sv
// Purpose: port checks for asc_top
// Assumes: one clock, sync reset
// Notes:   bound to every asc_top
`timescale 1ns/1ps
module asc_top_asserts
   import asc_pkg::*;
(
   // clock
   input wire logic              core_clk_in,
   input wire logic              rst_in,
   // bus
   input wire logic              bus_sel_in,
   input wire logic              bus_write_n_in,
   input wire logic              bus_ds0_n_in,
   input wire logic              bus_ds1_n_in,
   input wire logic              bus_iack_in,
   input wire logic              bus_data_oe_out,
   input wire logic              bus_ack_out,
   input wire logic [7:1]        bus_irq_n_out,
   // converter
   input wire logic [CHAN_W-1:0] channel_select_lines_out,
   input wire logic              hold_out,
   input wire logic              convert_strobe_out,
   input wire logic              conversion_in_progress_in
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   logic [15:0] quiet_q;
   wire         idle = bus_ds0_n_in & bus_ds1_n_in;
   // cycles since the channel last moved
   always_ff @(posedge core_clk_in) begin
      if (rst_in || $changed(channel_select_lines_out))
         quiet_q <= 16'h0000;
      else if (quiet_q != 16'hffff)
         quiet_q <= quiet_q + 16'h0001;
   end
   a_strobe_holds: assert property (
      convert_strobe_out |-> hold_out) else $error("strobe without hold");
   a_busy_holds: assert property (
      conversion_in_progress_in |-> hold_out) else $error("busy, no hold");
   a_settle_first: assert property (
      $rose(convert_strobe_out) |-> quiet_q >= SETTLE_CYC)
      else $error("convert before settle");
   a_strobe_drops: assert property (
      $rose(conversion_in_progress_in) |-> ##[0:2] !convert_strobe_out)
      else $error("strobe stuck");
   a_ack_follows: assert property (
      $fell(idle) && bus_sel_in && !bus_iack_in |=> bus_ack_out)
      else $error("no ack");
   a_ack_strobed: assert property (
      bus_ack_out |-> !idle) else $error("ack without strobe");
   a_oe_read: assert property (
      bus_data_oe_out |-> bus_write_n_in && bus_ack_out)
      else $error("drive on write");
   a_irq_clears: assert property (
      bus_iack_in && bus_ack_out |-> ##[1:4] (&bus_irq_n_out))
      else $error("request kept");
   c_convert: cover property ($rose(convert_strobe_out));
   c_iack: cover property (bus_iack_in && bus_ack_out);
   c_chan: cover property ($changed(channel_select_lines_out));
endmodule : asc_top_asserts

bind asc_top asc_top_asserts u_asc_top_asserts (.*);

// File: verification/asc_adc_model.sv
// Purpose: converter model facing asc_top
// Assumes: strobe held until busy seen
// Notes:   data {~chan, chan}, toggling when stale
`timescale 1ns/1ps
module asc_adc_model
   import asc_pkg::*;
(
   // clock
   input  wire logic              core_clk_in,
   input  wire logic              rst_in,
   // control
   input  wire logic              strobe_in,
   input  wire logic [CHAN_W-1:0] chan_in,
   input  wire logic [3:0]        lat_in,
   // converter
   output logic                   busy_out,
   output logic      [DATA_W-1:0] data_out
);
   logic [3:0]        n_q;
   logic [1:0]        h_q;
   logic [CHAN_W-1:0] c_q;
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         busy_out <= 1'b0;
         h_q      <= 2'h0;
         data_out <= 12'h000;
      end else if (busy_out) begin
         n_q <= n_q - 4'h1;
         if (n_q == 4'h0) begin
            busy_out <= 1'b0;
            h_q      <= 2'h3;
            data_out <= {~c_q, c_q};
         end
      end else if (strobe_in) begin
         busy_out <= 1'b1;
         n_q      <= lat_in;
         c_q      <= chan_in;
      end else if (h_q != 2'h0)
         h_q <= h_q - 2'h1;
      else
         data_out <= ~data_out;
   end
endmodule : asc_adc_model

// File: verification/adc_scan_sequencer_control_tb_top.sv
// Purpose: self-checking bench for asc_top
// Assumes: converter model on far side
// Notes:   reads queue expectations, monitor compares
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((e) !== (g)) begin \
   failures++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
`define WAIT(c) begin n = 0; while (!(c) && n < 40000) begin \
   @(negedge core_clk_in); n++; end \
   if (n >= 40000) begin failures++; results(); end end
module adc_scan_sequencer_control_tb_top;
   import asc_pkg::*;
   logic core_clk_in, rst_in, sel, wn, ds, iack, oe, ack, strobe;
   logic hold, busy, ack_p;
   logic [2:0]  lvl;
   logic [6:0]  addr;
   logic [15:0] wd, rd, v, mv, mm;
   logic [7:1]  irq_n;
   logic [5:0]  ch, chs;
   logic [11:0] adc;
   logic [3:0]  lat;
   logic [15:0] eq[$], mq[$];
   int          failures, tests_run, n;
   asc_top #(.BOARD_CODE(8'h3c), .TRACK_LONG_CNT(20)) u_asc_top (
      .core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(1'b1),
      .bus_sel_in(sel), .bus_addr_in(addr), .bus_write_n_in(wn),
      .bus_ds0_n_in(ds), .bus_ds1_n_in(ds), .bus_iack_in(iack),
      .bus_iack_lvl_in(lvl), .bus_data_in(wd), .bus_data_out(rd),
      .bus_data_oe_out(oe), .bus_ack_out(ack), .bus_irq_n_out(irq_n),
      .channel_select_lines_out(ch), .bit_ref_sel_out(),
      .hold_out(hold), .convert_strobe_out(strobe),
      .conversion_in_progress_in(busy), .adc_data_in(adc),
      .scan_length_straps_in(7'h02));
   asc_adc_model u_asc_adc_model (.core_clk_in(core_clk_in),
      .rst_in(rst_in), .strobe_in(strobe), .chan_in(ch), .lat_in(lat),
      .busy_out(busy), .data_out(adc));
   initial begin
      core_clk_in = 1'b0;
      forever #2 core_clk_in = ~core_clk_in;
   end
   task automatic results;
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : results
   task automatic acc(input logic w, ia, input logic [6:0] a,
                      input logic [15:0] d, e, m);
      int i;
      @(posedge core_clk_in) #1;
      {sel, iack, wn, ds, addr, wd} = {1'b1, ia, !w, 1'b0, a, d};
      if (!w) begin
         eq.push_back(e);
         mq.push_back(m);
      end
      i = 0;
      do @(negedge core_clk_in); while (ack !== 1'b1 && ++i < 50);
      if (i >= 50) begin
         failures++;
         results();
      end
      @(posedge core_clk_in) #1;
      {sel, iack, wn, ds} = 4'b0011;
   endtask : acc
   // monitor: oldest note against each read answer
   initial begin
      ack_p = 1'b0;
      forever begin
         @(negedge core_clk_in);
         if (ack === 1'b1 && !ack_p && wn === 1'b1) begin
            `CHK("note", 1'b1, eq.size() > 0)
            mv = eq.pop_front();
            mm = mq.pop_front();
            `CHK("read data", mv, rd & mm)
         end
         ack_p = ack;
      end
   end
   initial begin
      {sel, iack, wn, ds, addr, wd, lvl, lat} = {4'b0011, 26'h0, 4'h3};
      {failures, tests_run, rst_in} = {32'h0, 32'h0, 1'b1};
      void'($urandom(32'h5290ce67));
      repeat (3) @(posedge core_clk_in);
      #1 rst_in = 1'b0;
      acc(0, 0, REG_ID, 0, 16'h3c00, 16'hffff);
      acc(0, 0, 7'h08, 0, 16'h0000, 16'hffff);
      `CHK("first chan", 6'h00, ch)
      `WAIT(ch === 6'h01)
      `WAIT(ch === 6'h00)
      acc(0, 0, 7'h40, 0, 16'h0fc0, 16'h0fff);
      acc(0, 0, 7'h41, 0, 16'h0f81, 16'h0fff);
      $display("autoscan test done");
      chs = 6'($urandom);
      lat = 4'($urandom_range(9, 1));
      acc(1, 0, REG_CSR, {1'b1, chs, 9'h040}, 0, 0);
      `WAIT(busy === 1'b1)
      `WAIT(busy === 1'b0)
      repeat (3) @(negedge core_clk_in);
      acc(1, 0, REG_CSR, {1'b1, chs, 9'h044}, 0, 0);
      `WAIT(strobe === 1'b1)
      `CHK("track", 1'b1, n < SETTLE_CYC + TRACK_CYC)
      `CHK("chan", chs, ch)
      `WAIT(busy === 1'b1)
      `WAIT(busy === 1'b0)
      repeat (3) @(negedge core_clk_in);
      acc(0, 0, REG_CSR, 0, {1'b1, chs, 9'h048}, 16'hffff);
      acc(0, 0, REG_RES, 0, {4'h0, ~chs, chs}, 16'h0fff);
      acc(0, 0, REG_CSR, 0, {1'b1, chs, 9'h040}, 16'hffff);
      $display("poll test done");
      for (int l = 1; l < 8; l++) begin
         v = 16'($urandom);
         lvl = 3'(l);
         acc(1, 0, REG_ICTL, {v[7:0], 5'h00, 3'(l)}, 0, 0);
         acc(1, 0, REG_CSR, {1'b1, chs, 9'h080}, 0, 0);
         acc(1, 0, REG_CSR, {1'b1, chs, 9'h084}, 0, 0);
         `WAIT(irq_n[l] === 1'b0)
         acc(0, 1, 7'h00, 0, {8'h00, v[7:0]}, 16'h00ff);
      end
      $display("interrupt test done");
      acc(1, 0, REG_CSR, {1'b1, chs, 9'h0c0}, 0, 0);
      acc(1, 0, REG_CSR, {1'b1, chs, 9'h0c4}, 0, 0);
      `WAIT(ch === 6'h01)
      `WAIT(busy === 1'b1)
      `WAIT(busy === 1'b0)
      repeat (3) @(negedge core_clk_in);
      acc(0, 0, REG_CSR, 0, {1'b1, chs, 9'h0d8}, 16'hffff);
      acc(1, 0, REG_CSR, {1'b1, chs, 9'h0c4}, 0, 0);
      acc(0, 0, REG_CSR, 0, {1'b1, chs, 9'h0e8}, 16'hffff);
      $display("scan poll test done");
      results();
   end
endmodule : adc_scan_sequencer_control_tb_top
